//--- hw/intc_pkg.sv
package intc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [11:0] IDX_CMP0   = 12'h02E4;
  localparam logic [11:0] IDX_EN0    = 12'h02E5;
  localparam logic [11:0] IDX_SWEN   = 12'h02E6;
  localparam logic [11:0] IDX_GRP1   = 12'h02E7;
  localparam logic [11:0] IDX_CTEN   = 12'h02E8;
  localparam logic [11:0] IDX_CTFLG  = 12'h02E9;
  localparam logic [11:0] IDX_SWFLG  = 12'h02EA;
  localparam logic [11:0] IDX_SERCFG = 12'h02F2;
  localparam logic [11:0] IDX_SERFLG = 12'h02F3;
  localparam logic [11:0] IDX_EN2    = 12'h02F5;
  localparam logic [11:0] IDX_GCTL   = 12'h0300;

  localparam int ADR_W  = 14;
  localparam int DAT_W  = 32;
  localparam int IDX_LO = 2;
  localparam int NIB_W  = 4;

  // Bit positions inside the 4-bit registers
  localparam int B_D0 = 0;
  localparam int B_D1 = 1;
  localparam int B_D2 = 2;
  localparam int B_D3 = 3;

  // Own control register layout
  localparam int G_GIE  = 0;
  localparam int G_IRQ  = 1;
  localparam int G_BUSY = 2;
  localparam int G_VEC  = 4;

  localparam logic [2:0] SER_CFG_RST = 3'h6;
  localparam logic [3:0] NIB_ZERO    = 4'h0;

  // Timer event lines and pin counts
  localparam int CT_N  = 3;
  localparam int SW_N  = 2;
  localparam int TMR_N = CT_N + SW_N;
  localparam int PIN_N = 9;

  // Return-address save plus vector load, in system clocks
  localparam int ENTRY_CYCLES = 12;
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] SAVE_LAST = CNT_W'(ENTRY_CYCLES - 2);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_LOAD = 2'b11
  } entry_state_t;
endpackage : intc_pkg

//--- hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // Only the second stage is visible outside
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = async_in;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stable;
endmodule : pin_sync
`default_nettype wire

//--- hw/edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Levels in, one-cycle edge pulses out
  input  wire logic [W-1:0] lvl_in,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);
  typedef struct packed {
    logic [W-1:0] prev;
  } edge_state_t;

  edge_state_t s_r;
  edge_state_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = lvl_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Reset level is low, so a line high at release counts as a rise
  assign rise_out = lvl_in & ~s_r.prev;
  assign fall_out = ~lvl_in & s_r.prev;
endmodule : edge_detect
`default_nettype wire

//--- hw/cpu_interrupt_controller.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_controller (
  // Clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_in,
  // Wishbone classic slave
  input  wire logic                         wb_cyc_in,
  input  wire logic                         wb_stb_in,
  input  wire logic                         wb_we_in,
  input  wire logic [intc_pkg::ADR_W-1:0]   wb_adr_in,
  input  wire logic [3:0]                   wb_sel_in,
  input  wire logic [intc_pkg::DAT_W-1:0]   wb_dat_in,
  output logic      [intc_pkg::DAT_W-1:0]   wb_dat_out,
  output logic                              wb_ack_out,
  // Event sources on the system clock
  input  wire logic                         ct_2hz_in,
  input  wire logic                         ct_8hz_in,
  input  wire logic                         ct_32hz_in,
  input  wire logic                         sw_1hz_in,
  input  wire logic                         sw_10hz_in,
  input  wire logic                         serial_done_in,
  // Input port pins, asynchronous
  input  wire logic [3:0]                   port_group0_in,
  input  wire logic                         input_pin_group1_in,
  input  wire logic [3:0]                   port_group2_in,
  // Core handshake
  input  wire logic                         cpu_accept_in,
  output logic                              irq_req_out,
  output logic                              cpu_wake_out,
  output logic                              ret_push_out,
  output logic                              vector_load_out,
  output logic      [3:0]                   vector_out,
  // Configuration bits kept for neighbouring blocks
  output logic      [3:0]                   input_compare_out,
  output logic                              input_compare_bit_out,
  output logic                              heavy_load_mode_out,
  output logic                              lcd_drive_select_out,
  output logic      [2:0]                   serial_cfg_out
);
  import intc_pkg::*;

  typedef struct packed {
    logic [3:0]       cmp0;
    logic [3:0]       port_group0_pin_enable;
    logic             heavy_load_mode;
    logic             sw_second_enable;
    logic             sw_tenth_enable;
    logic             port_group1_pin_enable;
    logic             input_compare_bit;
    logic             lcd_drive_select;
    logic             ct_half_second_enable;
    logic             ct_eighth_enable;
    logic             ct_fast_enable;
    logic             ct_half_second_pending;
    logic             ct_eighth_pending;
    logic             ct_fast_pending;
    logic             sw_second_pending;
    logic             sw_tenth_pending;
    logic             port_group0_pending;
    logic             port_group1_pending;
    logic [2:0]       ser_cfg;
    logic             serial_done_enable;
    logic             serial_done_pending;
    logic             port_group2_pending;
    logic [3:0]       port_group2_pin_enable;
    logic             global_irq_on;
    logic             ack;
    logic [DAT_W-1:0] dat;
    logic             irq;
    entry_state_t     st;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       vec;
    logic             push;
    logic             load;
  } intc_state_t;

  intc_state_t s_r;
  intc_state_t s_nxt;

  // Nibble placed in the low bits of a bus word
  function automatic logic [DAT_W-1:0] nib(input logic [3:0] v);
    nib = {{(DAT_W - NIB_W){1'b0}}, v};
  endfunction : nib

  // Sticky flag: a set in the same cycle as a clear wins
  function automatic logic sticky(input logic cur, input logic clr,
                                  input logic set);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // Timer events: falling edges of the divider outputs
  // Lines idle low, so reset leaves no false fall
  logic [TMR_N-1:0] tmr_fall;

  edge_detect #(.W(TMR_N)) u_tmr_edge (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .lvl_in     ({ct_2hz_in, ct_8hz_in, ct_32hz_in, sw_1hz_in, sw_10hz_in}),
    .rise_out   (),
    .fall_out   (tmr_fall)
  );

  // Pins cross into the clock domain before any logic sees them
  logic [PIN_N-1:0] pin_sync_lvl;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;

  pin_sync #(.W(PIN_N)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({port_group2_in, input_pin_group1_in, port_group0_in}),
    .sync_out   (pin_sync_lvl)
  );

  edge_detect #(.W(PIN_N)) u_pin_edge (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .lvl_in     (pin_sync_lvl),
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  logic [3:0]  g0_any;
  logic        g1_any;
  logic [3:0]  g2_rise;
  logic        bus_req;
  logic        bus_rd;
  logic        bus_wr;
  logic [11:0] idx;
  logic [3:0]  wnib;
  logic        clr_ct;
  logic        clr_sw;
  logic        clr_ser;
  logic        grp_sw;
  logic        grp_ct;
  logic        grp_in;
  logic        grp_ser;
  logic [3:0]  rd_nib;
  logic [3:0]  gctl_lo;

  // Group 2 only wakes on rising edges; its fall pulses go unused
  assign g0_any  = pin_rise[3:0] | pin_fall[3:0];
  assign g1_any  = pin_rise[4] | pin_fall[4];
  assign g2_rise = pin_rise[8:5];

  // One access per request; ack in the cycle after it is seen
  assign bus_req = wb_cyc_in & wb_stb_in & ~s_r.ack;
  assign bus_rd  = bus_req & ~wb_we_in;
  assign bus_wr  = bus_req & wb_we_in & wb_sel_in[0];
  assign idx     = wb_adr_in[ADR_W-1:IDX_LO];
  assign wnib    = wb_dat_in[NIB_W-1:0];

  // Clearing reads of the three flag registers
  assign clr_ct  = bus_rd & (idx == IDX_CTFLG);
  assign clr_sw  = bus_rd & (idx == IDX_SWFLG);
  assign clr_ser = bus_rd & (idx == IDX_SERFLG);

  // Per-group requests, each gated by its own enables
  assign grp_sw  = (s_r.sw_second_pending & s_r.sw_second_enable)
                 | (s_r.sw_tenth_pending & s_r.sw_tenth_enable);
  assign grp_ct  = (s_r.ct_half_second_pending & s_r.ct_half_second_enable)
                 | (s_r.ct_eighth_pending & s_r.ct_eighth_enable)
                 | (s_r.ct_fast_pending & s_r.ct_fast_enable);
  assign grp_in  = (s_r.port_group0_pending
                    & (|s_r.port_group0_pin_enable))
                 | (s_r.port_group1_pending & s_r.port_group1_pin_enable)
                 | (s_r.port_group2_pending
                    & (|s_r.port_group2_pin_enable));
  assign grp_ser = s_r.serial_done_pending & s_r.serial_done_enable;

  // Status for software: entry busy and the live request
  assign gctl_lo = {1'b0, s_r.st != ST_IDLE, s_r.irq, s_r.global_irq_on};

  // Read mux; reserved and unmapped locations read as zero
  always_comb begin
    rd_nib = NIB_ZERO;
    unique case (idx)
      IDX_CMP0:   rd_nib = s_r.cmp0;
      IDX_EN0:    rd_nib = s_r.port_group0_pin_enable;
      IDX_SWEN:   rd_nib = {s_r.heavy_load_mode, 1'b0,
                            s_r.sw_second_enable, s_r.sw_tenth_enable};
      IDX_GRP1:   rd_nib = {1'b0, s_r.port_group1_pin_enable,
                            s_r.input_compare_bit, pin_sync_lvl[4]};
      IDX_CTEN:   rd_nib = {s_r.lcd_drive_select, s_r.ct_half_second_enable,
                            s_r.ct_eighth_enable, s_r.ct_fast_enable};
      IDX_CTFLG:  rd_nib = {1'b0, s_r.ct_half_second_pending,
                            s_r.ct_eighth_pending, s_r.ct_fast_pending};
      IDX_SWFLG:  rd_nib = {s_r.port_group1_pending, s_r.port_group0_pending,
                            s_r.sw_second_pending, s_r.sw_tenth_pending};
      IDX_SERCFG: rd_nib = {s_r.ser_cfg, s_r.serial_done_enable};
      IDX_SERFLG: rd_nib = {2'b00, s_r.port_group2_pending,
                            s_r.serial_done_pending};
      IDX_EN2:    rd_nib = s_r.port_group2_pin_enable;
      default:    rd_nib = NIB_ZERO;
    endcase
  end

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = bus_req;
    s_nxt.dat = '0;
    if (bus_rd) begin
      s_nxt.dat = nib(rd_nib);
      if (idx == IDX_GCTL) begin
        s_nxt.dat = {{(DAT_W - 8){1'b0}}, s_r.vec, gctl_lo};
      end
    end

    // Register writes; flag registers ignore writes
    if (bus_wr) begin
      unique case (idx)
        IDX_CMP0: s_nxt.cmp0 = wnib;
        IDX_EN0:  s_nxt.port_group0_pin_enable = wnib;
        IDX_SWEN: begin
          s_nxt.heavy_load_mode  = wnib[B_D3];
          s_nxt.sw_second_enable = wnib[B_D1];
          s_nxt.sw_tenth_enable  = wnib[B_D0];
        end
        IDX_GRP1: begin
          s_nxt.port_group1_pin_enable = wnib[B_D2];
          s_nxt.input_compare_bit      = wnib[B_D1];
        end
        IDX_CTEN: begin
          s_nxt.lcd_drive_select      = wnib[B_D3];
          s_nxt.ct_half_second_enable = wnib[B_D2];
          s_nxt.ct_eighth_enable      = wnib[B_D1];
          s_nxt.ct_fast_enable        = wnib[B_D0];
        end
        IDX_SERCFG: begin
          s_nxt.ser_cfg            = wnib[B_D3:B_D1];
          s_nxt.serial_done_enable = wnib[B_D0];
        end
        IDX_EN2:  s_nxt.port_group2_pin_enable = wnib;
        IDX_GCTL: s_nxt.global_irq_on = wnib[G_GIE];
        default:  s_nxt.dat = s_nxt.dat;
      endcase
    end

    // Timer flags set regardless of their enables
    s_nxt.ct_half_second_pending = sticky(s_r.ct_half_second_pending,
                                          clr_ct, tmr_fall[4]);
    s_nxt.ct_eighth_pending      = sticky(s_r.ct_eighth_pending,
                                          clr_ct, tmr_fall[3]);
    s_nxt.ct_fast_pending        = sticky(s_r.ct_fast_pending,
                                          clr_ct, tmr_fall[2]);
    s_nxt.sw_second_pending      = sticky(s_r.sw_second_pending,
                                          clr_sw, tmr_fall[1]);
    s_nxt.sw_tenth_pending       = sticky(s_r.sw_tenth_pending,
                                          clr_sw, tmr_fall[0]);
    s_nxt.serial_done_pending    = sticky(s_r.serial_done_pending,
                                          clr_ser, serial_done_in);

    // Pin flags only set through an enabled pin
    s_nxt.port_group0_pending = sticky(s_r.port_group0_pending, clr_sw,
      |(g0_any & s_r.port_group0_pin_enable));
    s_nxt.port_group1_pending = sticky(s_r.port_group1_pending, clr_sw,
      g1_any & s_r.port_group1_pin_enable);
    s_nxt.port_group2_pending = sticky(s_r.port_group2_pending, clr_ser,
      |(g2_rise & s_r.port_group2_pin_enable));

    // Entry sequence: push for eleven cycles, then one vector load
    unique case (s_r.st)
      ST_IDLE: begin
        if (cpu_accept_in && s_r.irq) begin
          s_nxt.st            = ST_SAVE;
          s_nxt.cnt           = '0;
          // Latched once; held until the next accept
          s_nxt.vec           = {grp_sw, grp_ct, grp_in, grp_ser};
          s_nxt.global_irq_on = 1'b0;
        end
      end
      ST_SAVE: begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == SAVE_LAST) begin
          s_nxt.st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Strobes to the core come straight from flops
    s_nxt.push = (s_nxt.st == ST_SAVE);
    s_nxt.load = (s_nxt.st == ST_LOAD);

    // Held off during entry so one request yields one vector
    s_nxt.irq = s_nxt.global_irq_on & (s_nxt.st == ST_IDLE)
              & (grp_sw | grp_ct | grp_in | grp_ser);
  end

  // Reset loads constants only; serial config restarts at its default
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_r         <= '0;
      s_r.ser_cfg <= SER_CFG_RST;
      s_r.st      <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_out            = s_r.dat;
  assign wb_ack_out            = s_r.ack;
  assign irq_req_out           = s_r.irq;
  assign cpu_wake_out          = s_r.irq;
  assign ret_push_out          = s_r.push;
  assign vector_load_out       = s_r.load;
  assign vector_out            = s_r.vec;
  assign input_compare_out     = s_r.cmp0;
  assign input_compare_bit_out = s_r.input_compare_bit;
  assign heavy_load_mode_out   = s_r.heavy_load_mode;
  assign lcd_drive_select_out  = s_r.lcd_drive_select;
  assign serial_cfg_out        = s_r.ser_cfg;
endmodule : cpu_interrupt_controller
`default_nettype wire

//--- tb/intc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module intc_properties (
  // Clock and reset
  input wire logic                       sys_clk_in,
  input wire logic                       rst_in,
  // Register bus
  input wire logic                       wb_cyc_in,
  input wire logic                       wb_stb_in,
  input wire logic                       wb_ack_out,
  input wire logic [intc_pkg::DAT_W-1:0] wb_dat_out,
  // Core handshake
  input wire logic                       cpu_accept_in,
  input wire logic                       irq_req_out,
  input wire logic                       cpu_wake_out,
  input wire logic                       ret_push_out,
  input wire logic                       vector_load_out,
  input wire logic [3:0]                 vector_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence accept_s; cpu_accept_in && irq_req_out; endsequence
  // Eleven save cycles, split since repetition stops at eight
  sequence save_s; ret_push_out [*8] ##1 ret_push_out [*3]; endsequence
  sequence load_s; vector_load_out && !ret_push_out; endsequence
  bus_answer_a: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!wb_ack_out |-> wb_dat_out == '0)
    else $error("read data outside ack");
  entry_timing_a: assert property (accept_s |=> save_s ##1 load_s)
    else $error("entry sequence not twelve cycles");
  accept_drop_a: assert property (accept_s |=> !irq_req_out)
    else $error("request stays after accept");
  wake_match_a: assert property (cpu_wake_out == irq_req_out)
    else $error("wake differs from request");
  push_cause_a: assert property (
    $rose(ret_push_out) |-> $past(cpu_accept_in && irq_req_out))
    else $error("save without accept");
  vector_range_a: assert property (vector_load_out |-> vector_out != 4'h0)
    else $error("vector zero at load");
  vector_hold_a: assert property (
    ret_push_out && $past(ret_push_out) |-> $stable(vector_out))
    else $error("vector moved during entry");
  load_end_a: assert property (
    vector_load_out |=> !vector_load_out && !ret_push_out)
    else $error("load pulse too long");
endmodule : intc_properties

bind cpu_interrupt_controller intc_properties intc_properties_i (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
  .cpu_accept_in(cpu_accept_in), .irq_req_out(irq_req_out),
  .cpu_wake_out(cpu_wake_out), .ret_push_out(ret_push_out),
  .vector_load_out(vector_load_out), .vector_out(vector_out));
`default_nettype wire

//--- tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Request in, lag in cycles, accept out
  input  wire logic       irq_req_in,
  input  wire logic [3:0] lag_in,
  output logic            accept_out
);
  int wait_cnt = 0;
  initial accept_out = 1'b0;
  // Lag stands for the instruction still running when the request comes
  always @(posedge sys_clk_in) begin
    accept_out <= 1'b0;
    if (rst_in || !irq_req_in || accept_out) begin
      wait_cnt <= 0;
    end else if (wait_cnt >= int'(lag_in)) begin
      accept_out <= 1'b1;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : core_model
`default_nettype wire

//--- tb/tb_cpu_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_controller;
  import intc_pkg::*;
  logic sys_clk_in = 1'b0, rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ser = 1'b0, pg1 = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0, rdat;
  logic [3:0] sel = 4'h0, lag = 4'h0, pg0 = 4'h0, pg2 = 4'h0, vec;
  logic [4:0] tmr = 5'h00;
  logic ack, accept, irq, push, vload, icb, hlm, lcd;
  logic [2:0] scfg;
  logic [3:0] icmp;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  int mreg [int];
  logic [11:0] regs [12] = '{IDX_CMP0, IDX_EN0, IDX_SWEN, IDX_GRP1,
    IDX_CTEN, IDX_CTFLG, IDX_SWFLG, IDX_SERCFG, IDX_SERFLG, IDX_EN2,
    IDX_GCTL, 12'h100};

  cpu_interrupt_controller cpu_interrupt_controller_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .ct_2hz_in(tmr[4]), .ct_8hz_in(tmr[3]), .ct_32hz_in(tmr[2]),
    .sw_1hz_in(tmr[1]), .sw_10hz_in(tmr[0]), .serial_done_in(ser),
    .port_group0_in(pg0), .input_pin_group1_in(pg1),
    .port_group2_in(pg2), .cpu_accept_in(accept), .irq_req_out(irq),
    .cpu_wake_out(), .ret_push_out(push), .vector_load_out(vload),
    .vector_out(vec), .input_compare_out(icmp), .input_compare_bit_out(icb),
    .heavy_load_mode_out(hlm), .lcd_drive_select_out(lcd),
    .serial_cfg_out(scfg));
  core_model core_model_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .irq_req_in(irq), .lag_in(lag), .accept_out(accept));

  always #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [DAT_W-1:0] g, e, input string s);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick

  function automatic logic [3:0] wmask(input logic [11:0] i);
    case (i)
      IDX_SWEN: return 4'hB;
      IDX_GRP1: return 4'h6;
      IDX_GCTL: return 4'h1;
      IDX_CMP0, IDX_EN0, IDX_CTEN, IDX_SERCFG, IDX_EN2: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction : wmask

  // Group bits of the vector from model flags and enables
  function automatic logic [3:0] exp_vec();
    return {|(mreg[IDX_SWFLG][1:0] & mreg[IDX_SWEN][1:0]),
      |(mreg[IDX_CTFLG][2:0] & mreg[IDX_CTEN][2:0]),
      (mreg[IDX_SWFLG][2] && mreg[IDX_EN0] != 0) ||
      (mreg[IDX_SWFLG][3] && mreg[IDX_GRP1][2]) ||
      (mreg[IDX_SERFLG][1] && mreg[IDX_EN2] != 0),
      mreg[IDX_SERFLG][0] & mreg[IDX_SERCFG][0]};
  endfunction : exp_vec

  task automatic bus(input logic w, input logic [11:0] i,
                     input logic [3:0] d, output logic [DAT_W-1:0] q);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {i, 2'b00};
    wdat <= {28'h000_0000, d};
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("wrong value at %0t: no bus ack", $time);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] i, input logic [3:0] d);
    logic [DAT_W-1:0] q;
    bus(1'b1, i, d, q);
    if (wmask(i) != 4'h0) mreg[i] = d & wmask(i);
  endtask : wr

  task automatic rd(input logic [11:0] i);
    logic [DAT_W-1:0] q;
    logic [3:0] e;
    bus(1'b0, i, 4'h0, q);
    e = mreg[i][3:0] | ((i == IDX_GRP1) ? {3'h0, pg1} : 4'h0);
    if (i == IDX_GCTL) q = q & 32'h0000_0001;
    chk(q, {28'h000_0000, e}, "register read");
    chk({icmp, icb, hlm, lcd, scfg}, {mreg[IDX_CMP0][3:0],
      mreg[IDX_GRP1][1], mreg[IDX_SWEN][3], mreg[IDX_CTEN][3],
      mreg[IDX_SERCFG][3:1]}, "config copies");
    if (i inside {IDX_CTFLG, IDX_SWFLG, IDX_SERFLG}) mreg[i] = 0;
  endtask : rd

  // Global enable is off whenever flags are read
  task automatic rdflags();
    chk(irq, 1'b0, "request while disabled");
    repeat (2) begin
      rd(IDX_CTFLG);
      rd(IDX_SWFLG);
      rd(IDX_SERFLG);
    end
  endtask : rdflags

  task automatic ev(input logic [4:0] t, input logic s,
                    input logic [3:0] p0, input logic p1, input logic [3:0] p2);
    @(posedge sys_clk_in);
    tmr <= t;
    ser <= s;
    pg0 <= pg0 ^ p0;
    pg1 <= pg1 ^ p1;
    pg2 <= pg2 ^ p2;
    @(posedge sys_clk_in);
    tmr <= 5'h00;
    ser <= 1'b0;
    tick(6);
    mreg[IDX_CTFLG] |= t[4:2];
    mreg[IDX_SWFLG] |= {p1 & mreg[IDX_GRP1][2],
      |(p0 & mreg[IDX_EN0][3:0]), t[1:0]};
    mreg[IDX_SERFLG] |= {|(p2 & pg2 & mreg[IDX_EN2][3:0]), s};
  endtask : ev

  task automatic entry();
    int n, p;
    n = 0;
    p = 0;
    while (!(accept === 1'b1 && irq === 1'b1) && n < 40) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(irq, 1'b1, "request");
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
      p += int'(push === 1'b1);
    end while (vload !== 1'b1 && n < 40);
    chk(n, ENTRY_CYCLES, "entry length");
    chk(p, ENTRY_CYCLES - 1, "save length");
    chk(vec, exp_vec(), "vector");
    mreg[IDX_GCTL] = 0;
    rd(IDX_GCTL);
  endtask : entry

  initial begin
    void'($urandom(32'h0000_08f2));
    foreach (regs[k]) mreg[regs[k]] = 0;
    mreg[IDX_SERCFG] = 4'hC;
    tick(12);
    rst_in <= 1'b0;
    tick(4);
    foreach (regs[k]) rd(regs[k]);
    $display("test reset values done");
    repeat (3) begin
      foreach (regs[k]) if (regs[k] != IDX_GCTL) wr(regs[k], 4'($urandom));
      foreach (regs[k]) rd(regs[k]);
    end
    foreach (regs[k]) wr(regs[k], 4'h0);
    $display("test enable access done");
    ev(5'h1F, 1'b1, 4'hF, 1'b1, 4'hF);
    rdflags();
    wr(IDX_EN0, 4'h4);
    wr(IDX_GRP1, 4'h4);
    wr(IDX_EN2, 4'h2);
    ev(5'h00, 1'b0, 4'h4, 1'b1, 4'h2);
    rdflags();
    ev(5'h00, 1'b0, 4'h1, 1'b0, 4'h2);
    rdflags();
    $display("test flag sources done");
    repeat (12) begin
      foreach (regs[k]) if (wmask(regs[k]) == 4'hF) wr(regs[k], 4'($urandom));
      wr(IDX_SWEN, 4'($urandom));
      wr(IDX_GRP1, 4'($urandom));
      ev(5'($urandom), 1'($urandom), 4'($urandom), 1'($urandom),
         4'($urandom));
      lag <= 4'($urandom_range(0, 9));
      if (exp_vec() != 4'h0) begin
        wr(IDX_GCTL, 4'h1);
        entry();
      end
      rdflags();
    end
    $display("test interrupt entry done");
    end_of_test();
  end
endmodule : tb_cpu_interrupt_controller
`default_nettype wire
